/* File: mcuex_cfg.svh */
`ifndef MCUEX_CFG_SVH
`define MCUEX_CFG_SVH

// Register byte offsets on the bus
`define EX_OFF_INSTR   8'h00
`define EX_OFF_ACC     8'h04
`define EX_OFF_MEM     8'h08
`define EX_OFF_FLAGS   8'h0C
`define EX_OFF_PC      8'h10
`define EX_OFF_TBLW    8'h14
`define EX_OFF_TBLR    8'h18
`define EX_OFF_EXEC    8'h1C

// Flag bit positions in the flags register
`define EX_F_C         0
`define EX_F_AC        1
`define EX_F_Z         2
`define EX_F_OV        3
`define EX_F_PDF       4
`define EX_F_TO        5

// Instruction word fields
`define EX_I_OP_HI     5
`define EX_I_BIT_LO    8
`define EX_I_ADDR_LO   16
`define EX_I_TGT_LO    24

// Timing and structure
`define EX_CLK_PER_CYC 4'h4
`define EX_PCL_ADDR    8'h02
`define EX_LAST_PAGE   5'h1F
`define EX_STACK_N     16
`define EX_BCD_MAX     5'h09
`define EX_BCD_FIX     5'h06

// Reset values
`define EX_RST_PC      13'h0000
`define EX_RST_BYTE    8'h00
`define EX_RST_WORD    32'h0000_0000

`endif

/* File: mcuex_pkg.sv */
`default_nettype none
package mcuex_pkg;

    // Instruction codes, one per instruction
    typedef enum logic [5:0] {
        OP_ADD_AM = 6'b000000, OP_ADDM = 6'b000001, OP_ADD_AX = 6'b000010,
        OP_ADC_AM = 6'b000011, OP_ADCM = 6'b000100, OP_SUB_AX = 6'b000101,
        OP_SUB_AM = 6'b000110, OP_SUBM = 6'b000111, OP_SBC_AM = 6'b001000,
        OP_SBCM   = 6'b001001, OP_DADJ = 6'b001010, OP_AND_AM = 6'b001011,
        OP_OR_AM  = 6'b001100, OP_XOR_AM = 6'b001101, OP_ANDM = 6'b001110,
        OP_ORM    = 6'b001111, OP_XORM = 6'b010000, OP_AND_AX = 6'b010001,
        OP_OR_AX  = 6'b010010, OP_XOR_AX = 6'b010011, OP_CPL = 6'b010100,
        OP_CPLA   = 6'b010101, OP_INCA = 6'b010110, OP_INC = 6'b010111,
        OP_DECA   = 6'b011000, OP_DEC = 6'b011001, OP_RRA = 6'b011010,
        OP_RR     = 6'b011011, OP_RRCA = 6'b011100, OP_RRC = 6'b011101,
        OP_RLA    = 6'b011110, OP_RL = 6'b011111, OP_RLCA = 6'b100000,
        OP_RLC    = 6'b100001, OP_MOV_AM = 6'b100010, OP_MOV_MA = 6'b100011,
        OP_MOV_AX = 6'b100100, OP_CLRB = 6'b100101, OP_SETB = 6'b100110,
        OP_JMP    = 6'b100111, OP_SZ = 6'b101000, OP_SZA = 6'b101001,
        OP_SZB    = 6'b101010, OP_SNZB = 6'b101011, OP_SIZ = 6'b101100,
        OP_SDZ    = 6'b101101, OP_SIZA = 6'b101110, OP_SDZA = 6'b101111,
        OP_CALL   = 6'b110000, OP_RET = 6'b110001, OP_RETAX = 6'b110010,
        OP_RETI   = 6'b110011, OP_TBRC = 6'b110100, OP_TBRL = 6'b110101,
        OP_NOP    = 6'b110110, OP_CLRM = 6'b110111, OP_SETM = 6'b111000,
        OP_WDCLR  = 6'b111001, OP_WDP1 = 6'b111010, OP_WDP2 = 6'b111011,
        OP_SWAP   = 6'b111100, OP_SWAPA = 6'b111101, OP_HALT = 6'b111110
    } mcuex_op_t;

    // Whole state of the execution block
    typedef struct packed {
        logic [7:0]        acc;
        logic [7:0]        mem;
        logic              c, ac, z, ov, sleep_entered_flag, to;
        logic [12:0]       pc;
        logic [15:0]       tblw;
        logic [7:0]        table_high_latch;
        logic [12:0]       tbla;
        logic [31:0]       instr;
        logic              busy;
        logic [3:0]        cnt;
        logic              skip;
        logic              pcl_wr;
        logic              halted;
        logic              two_times;
        logic              wd1_seen;
        logic              wd2_seen;
        logic              wdt_clr;
        logic [3:0]        sp;
        logic [15:0][12:0] stack;
        logic              ap_valid;
        logic              ap_write;
        logic [7:0]        ap_addr;
        logic [31:0]       rdata;
        logic              rdy;
    } mcuex_state_t;

endpackage
`default_nettype wire

/* File: mcuex_exec.sv */
// Design decisions made here: the AHB-Lite register port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
`include "mcuex_cfg.svh"

module mcuex_exec
    import mcuex_pkg::*;
(
    // Clock and reset
    input  wire logic        hclk,
    input  wire logic        hresetn,
    // AHB-Lite slave
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic      [31:0] hrdata,
    output logic             hreadyout,
    output logic             hresp,
    // Core status
    output logic             busy,
    output logic             halted,
    output logic             wdt_clear
);

    mcuex_state_t s;
    mcuex_state_t n;

    // Adder returning {carry, half carry, overflow, sum}
    function automatic logic [10:0] add8(input logic [7:0] a,
                                         input logic [7:0] b,
                                         input logic       ci);
        logic [4:0] lo;
        logic [8:0] full;
        logic       ov;
        lo   = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, ci};
        full = {1'b0, a} + {1'b0, b} + {8'h00, ci};
        ov   = (a[7] == b[7]) && (full[7] != a[7]);
        return {full[8], lo[4], ov, full[7:0]};
    endfunction

    // Next state: bus slave, launch and execute
    always_comb begin
        logic        go;
        logic [7:0]  b;
        logic [7:0]  res;
        logic [10:0] sm;
        logic [4:0]  dl;
        logic [4:0]  dh;
        logic [2:0]  cyc;
        logic        wm;
        logic        wa;
        logic        setz;
        logic        skp;
        logic        jumped;
        logic        wdok;
        logic [7:0]  ma;
        logic [2:0]  bi;
        mcuex_op_t   op;
        go     = 1'b0;
        b      = 8'h00;
        res    = 8'h00;
        sm     = 11'h000;
        dl     = 5'h00;
        dh     = 5'h00;
        cyc    = 3'h1;
        wm     = 1'b0;
        wa     = 1'b0;
        setz   = 1'b0;
        skp    = 1'b0;
        jumped = 1'b0;
        wdok   = 1'b0;
        ma     = 8'h00;
        bi     = 3'h0;
        op     = OP_NOP;
        n         = s;
        n.wdt_clr = 1'b0;
        n.rdy     = 1'b1;

        // Instruction cycle countdown
        if (s.busy) begin
            n.cnt = s.cnt - 4'h1;
            if (s.cnt == 4'h1) begin
                n.busy = 1'b0;
            end
        end

        // Data phase of a write
        if (s.ap_valid && s.ap_write) begin
            case (s.ap_addr)
                `EX_OFF_INSTR: begin
                    // Refused while busy or halted
                    if (!s.busy && !s.halted) begin
                        n.instr = hwdata;
                        go      = 1'b1;
                    end
                end
                `EX_OFF_ACC:   n.acc = hwdata[7:0];
                `EX_OFF_MEM:   n.mem = hwdata[7:0];
                `EX_OFF_FLAGS: begin
                    n.c   = hwdata[`EX_F_C];
                    n.ac  = hwdata[`EX_F_AC];
                    n.z   = hwdata[`EX_F_Z];
                    n.ov  = hwdata[`EX_F_OV];
                    n.sleep_entered_flag = hwdata[`EX_F_PDF];
                    n.to  = hwdata[`EX_F_TO];
                end
                `EX_OFF_PC:    n.pc = hwdata[12:0];
                `EX_OFF_TBLW:  n.tblw = hwdata[15:0];
                `EX_OFF_EXEC: begin
                    n.two_times = hwdata[0];
                    if (hwdata[1]) begin
                        n.halted = 1'b0;
                    end
                end
                default: ;
            endcase
        end

        op = mcuex_op_t'(n.instr[`EX_I_OP_HI:0]);
        ma = n.instr[`EX_I_ADDR_LO+7:`EX_I_ADDR_LO];
        bi = n.instr[`EX_I_BIT_LO+2:`EX_I_BIT_LO];

        // Execute the launched instruction
        if (go) begin
            b = n.mem;
            case (op)
                OP_ADD_AM, OP_ADDM, OP_ADD_AX, OP_ADC_AM, OP_ADCM: begin
                    if (op == OP_ADD_AX) begin
                        b = ma;
                    end
                    sm = add8(n.acc, b, (op == OP_ADC_AM || op == OP_ADCM)
                              ? n.c : 1'b0);
                    res = sm[7:0];
                    {n.c, n.ac, n.ov} = sm[10:8];
                    setz = 1'b1;
                    wm = (op == OP_ADDM || op == OP_ADCM);
                    wa = !wm;
                end
                OP_SUB_AX, OP_SUB_AM, OP_SUBM, OP_SBC_AM, OP_SBCM: begin
                    if (op == OP_SUB_AX) begin
                        b = ma;
                    end
                    // Carry set means no borrow
                    sm = add8(n.acc, ~b, (op == OP_SBC_AM || op == OP_SBCM)
                              ? n.c : 1'b1);
                    res = sm[7:0];
                    {n.c, n.ac, n.ov} = sm[10:8];
                    setz = 1'b1;
                    wm = (op == OP_SUBM || op == OP_SBCM);
                    wa = !wm;
                end
                OP_DADJ: begin
                    dl = {1'b0, n.acc[3:0]};
                    if (dl > `EX_BCD_MAX || n.ac) begin
                        dl = dl + `EX_BCD_FIX;
                    end
                    dh = {1'b0, n.acc[7:4]} + {4'h0, dl[4]};
                    if (dh > `EX_BCD_MAX || n.c) begin
                        dh  = dh + `EX_BCD_FIX;
                        n.c = 1'b1;
                    end
                    res = {dh[3:0], dl[3:0]};
                    wm  = 1'b1;
                end
                OP_AND_AM, OP_ANDM, OP_AND_AX, OP_OR_AM, OP_ORM, OP_OR_AX,
                OP_XOR_AM, OP_XORM, OP_XOR_AX: begin
                    if (op == OP_AND_AX || op == OP_OR_AX
                        || op == OP_XOR_AX) begin
                        b = ma;
                    end
                    if (op == OP_AND_AM || op == OP_ANDM
                        || op == OP_AND_AX) begin
                        res = n.acc & b;
                    end else if (op == OP_OR_AM || op == OP_ORM
                                 || op == OP_OR_AX) begin
                        res = n.acc | b;
                    end else begin
                        res = n.acc ^ b;
                    end
                    setz = 1'b1;
                    wm = (op == OP_ANDM || op == OP_ORM || op == OP_XORM);
                    wa = !wm;
                end
                OP_CPL, OP_CPLA: begin
                    res  = ~b;
                    setz = 1'b1;
                    wm   = (op == OP_CPL);
                    wa   = !wm;
                end
                OP_INC, OP_INCA, OP_DEC, OP_DECA: begin
                    res = (op == OP_INC || op == OP_INCA)
                          ? b + 8'h01 : b - 8'h01;
                    setz = 1'b1;
                    wm = (op == OP_INC || op == OP_DEC);
                    wa = !wm;
                end
                OP_RR, OP_RRA: begin
                    res = {b[0], b[7:1]};
                    wm  = (op == OP_RR);
                    wa  = !wm;
                end
                OP_RL, OP_RLA: begin
                    res = {b[6:0], b[7]};
                    wm  = (op == OP_RL);
                    wa  = !wm;
                end
                OP_RRC, OP_RRCA: begin
                    res = {n.c, b[7:1]};
                    n.c = b[0];
                    wm  = (op == OP_RRC);
                    wa  = !wm;
                end
                OP_RLC, OP_RLCA: begin
                    res = {b[6:0], n.c};
                    n.c = b[7];
                    wm  = (op == OP_RLC);
                    wa  = !wm;
                end
                OP_MOV_AM: begin
                    res = b;
                    wa  = 1'b1;
                end
                OP_MOV_AX: begin
                    res = ma;
                    wa  = 1'b1;
                end
                OP_MOV_MA: begin
                    res = n.acc;
                    wm  = 1'b1;
                end
                OP_CLRB, OP_SETB: begin
                    res     = b;
                    res[bi] = (op == OP_SETB);
                    wm      = 1'b1;
                end
                OP_SZ, OP_SZA: begin
                    skp = (b == 8'h00);
                    res = b;
                    wa  = (op == OP_SZA);
                end
                OP_SZB:  skp = !b[bi];
                OP_SNZB: skp = b[bi];
                OP_SIZ, OP_SIZA, OP_SDZ, OP_SDZA: begin
                    res = (op == OP_SIZ || op == OP_SIZA)
                          ? b + 8'h01 : b - 8'h01;
                    skp = (res == 8'h00);
                    wm  = (op == OP_SIZ || op == OP_SDZ);
                    wa  = !wm;
                end
                OP_JMP: begin
                    n.pc   = n.instr[28:16];
                    jumped = 1'b1;
                    cyc    = 3'h2;
                end
                OP_CALL: begin
                    n.stack[n.sp] = 13'(n.pc + 13'h0001);
                    n.sp   = 4'(n.sp + 4'h1);
                    n.pc   = n.instr[28:16];
                    jumped = 1'b1;
                    cyc    = 3'h2;
                end
                OP_RET, OP_RETAX, OP_RETI: begin
                    n.sp   = 4'(n.sp - 4'h1);
                    n.pc   = n.stack[n.sp];
                    jumped = 1'b1;
                    cyc    = 3'h2;
                    if (op == OP_RETAX) begin
                        res = ma;
                        wa  = 1'b1;
                    end
                end
                OP_TBRC, OP_TBRL: begin
                    // Word is supplied by software in the table word reg
                    n.tbla = (op == OP_TBRC) ? {n.pc[12:8], b}
                             : {`EX_LAST_PAGE, b};
                    res    = n.tblw[7:0];
                    n.table_high_latch = n.tblw[15:8];
                    wm     = 1'b1;
                    cyc    = 3'h2;
                end
                OP_CLRM: begin
                    res = 8'h00;
                    wm  = 1'b1;
                end
                OP_SETM: begin
                    res = 8'hFF;
                    wm  = 1'b1;
                end
                OP_WDCLR: wdok = 1'b1;
                OP_WDP1, OP_WDP2: begin
                    // Two-times option needs both pre-clears
                    if (!n.two_times) begin
                        wdok = 1'b1;
                    end else if (op == OP_WDP1 ? n.wd2_seen : n.wd1_seen) begin
                        wdok = 1'b1;
                    end else if (op == OP_WDP1) begin
                        n.wd1_seen = 1'b1;
                    end else begin
                        n.wd2_seen = 1'b1;
                    end
                end
                OP_SWAP, OP_SWAPA: begin
                    res = {b[3:0], b[7:4]};
                    wm  = (op == OP_SWAP);
                    wa  = !wm;
                end
                OP_HALT: begin
                    n.halted  = 1'b1;
                    n.wdt_clr = 1'b1;
                    n.sleep_entered_flag     = 1'b1;
                    n.to      = 1'b0;
                    n.wd1_seen = 1'b0;
                    n.wd2_seen = 1'b0;
                end
                default: ;
            endcase

            // Watchdog cleared: expiry and sleep flags drop
            if (wdok) begin
                n.wdt_clr  = 1'b1;
                n.sleep_entered_flag      = 1'b0;
                n.to       = 1'b0;
                n.wd1_seen = 1'b0;
                n.wd2_seen = 1'b0;
            end
            if (setz) begin
                n.z = (res == 8'h00);
            end
            if (wa) begin
                n.acc = res;
            end
            if (wm) begin
                n.mem = res;
            end

            // Program counter advance and extra cycles
            n.pcl_wr = wm && (ma == `EX_PCL_ADDR);
            n.skip   = skp;
            if (n.pcl_wr) begin
                n.pc = {n.pc[12:8], res};
                cyc  = 3'(cyc + 3'h1);
            end else if (!jumped) begin
                n.pc = 13'(n.pc + (skp ? 13'h0002 : 13'h0001));
            end
            if (skp) begin
                cyc = 3'(cyc + 3'h1);
            end
            n.cnt  = 4'(cyc * `EX_CLK_PER_CYC);
            n.busy = 1'b1;
        end

        // Address phase capture and read data for the next data phase
        n.ap_valid = hsel && htrans[1] && hready;
        n.ap_write = hwrite;
        n.ap_addr  = {haddr[7:2], 2'b00};
        n.rdata    = `EX_RST_WORD;
        if (n.ap_valid && !hwrite) begin
            case (n.ap_addr)
                `EX_OFF_INSTR: n.rdata = n.instr;
                `EX_OFF_ACC:   n.rdata = {24'h000000, n.acc};
                `EX_OFF_MEM:   n.rdata = {24'h000000, n.mem};
                `EX_OFF_FLAGS: n.rdata = {26'h0, n.to, n.sleep_entered_flag, n.ov,
                                          n.z, n.ac, n.c};
                `EX_OFF_PC:    n.rdata = {19'h0, n.pc};
                `EX_OFF_TBLW:  n.rdata = {16'h0000, n.tblw};
                `EX_OFF_TBLR:  n.rdata = {11'h0, n.tbla, n.table_high_latch};
                `EX_OFF_EXEC:  n.rdata = {21'h0, n.sp, n.wd2_seen,
                                          n.wd1_seen, n.pcl_wr, n.skip,
                                          n.halted, n.busy, n.two_times};
                default:       n.rdata = `EX_RST_WORD;
            endcase
        end
    end

    // State register
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            s        <= '0;
            s.pc     <= `EX_RST_PC;
            s.acc    <= `EX_RST_BYTE;
            s.rdata  <= `EX_RST_WORD;
            s.rdy    <= 1'b1;
        end else begin
            s <= n;
        end
    end

    // Outputs straight from the state flops
    assign hrdata    = s.rdata;
    assign hreadyout = s.rdy;
    assign hresp     = 1'b0 & s.rdy;
    assign busy      = s.busy;
    assign halted    = s.halted;
    assign wdt_clear = s.wdt_clr;

endmodule
`default_nettype wire

/* File: mcuex_exec_properties.sv */
`timescale 1ns/1ps
`default_nettype none
module mcuex_exec_properties
    import mcuex_pkg::*;
(
    // Clock and reset
    input wire logic        hclk,
    input wire logic        hresetn,
    // Bus request side
    input wire logic        hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0]  htrans,
    input wire logic        hwrite,
    input wire logic        hready,
    input wire logic [31:0] hwdata,
    // Core status
    input wire logic        busy,
    input wire logic        halted,
    input wire logic        wdt_clear
);
    logic       wr_reg;
    logic       go_reg;
    logic [5:0] op_reg;
    logic [7:0] ad_reg;

    // Launch marker; a write while busy or halted is dropped
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_reg <= 1'b0;
            go_reg <= 1'b0;
            op_reg <= 6'h00;
            ad_reg <= 8'h00;
        end else begin
            wr_reg <= hsel && htrans[1] && hready && hwrite
                      && haddr[7:2] == 6'h00;
            go_reg <= wr_reg && !busy && !halted;
            op_reg <= hwdata[5:0];
            ad_reg <= hwdata[23:16];
        end
    end

    default clocking cb @(posedge hclk);
    endclocking
    default disable iff (!hresetn);

    // Busy spans of one and two instruction cycles
    sequence s_one;
        busy [*4] ##1 !busy;
    endsequence
    sequence s_two;
        busy [*8] ##1 !busy;
    endsequence

    AST_MOVE_ONE: assert property (
        go_reg && op_reg inside {OP_MOV_AM, OP_MOV_AX} |-> s_one)
        else $error("move not one cycle");
    AST_BRANCH_TWO: assert property (
        go_reg && op_reg inside {OP_JMP, OP_CALL, OP_RET, OP_RETI}
        |-> s_two) else $error("branch not two cycles");
    AST_PCL_EXTRA: assert property (
        go_reg && op_reg == OP_MOV_MA && ad_reg == 8'h02 |-> s_two)
        else $error("pc low write without extra cycle");
    AST_SKIP_SPAN: assert property (
        go_reg && op_reg == OP_SZ |-> s_one or s_two)
        else $error("skip span wrong");
    AST_CLEAR_PULSE: assert property (
        go_reg && op_reg == OP_WDCLR |-> wdt_clear ##1 !wdt_clear)
        else $error("watchdog clear pulse wrong");
    AST_NO_STRAY_CLEAR: assert property (
        wdt_clear |-> go_reg
        && op_reg inside {OP_WDCLR, OP_WDP1, OP_WDP2, OP_HALT})
        else $error("watchdog cleared without cause");
    AST_HALT_STOPS: assert property (
        go_reg && op_reg == OP_HALT |-> wdt_clear ##[0:1] halted)
        else $error("halt did not stop core");
    AST_HALT_HOLDS: assert property (
        $rose(halted) |-> halted [*8])
        else $error("halt released early");
endmodule

bind mcuex_exec mcuex_exec_properties mcuex_exec_properties_i (
    .hclk      (hclk),
    .hresetn   (hresetn),
    .hsel      (hsel),
    .haddr     (haddr),
    .htrans    (htrans),
    .hwrite    (hwrite),
    .hready    (hready),
    .hwdata    (hwdata),
    .busy      (busy),
    .halted    (halted),
    .wdt_clear (wdt_clear)
);
`default_nettype wire

/* File: mcuex_prog_mem.sv */
`timescale 1ns/1ps
`default_nettype none
module mcuex_prog_mem (
    // Table address
    input  wire logic [12:0] addr,
    // Program word
    output logic      [15:0] word
);
    // Halves differ so a swapped latch shows up
    assign word = {~addr[7:0], addr[12:5]};
endmodule
`default_nettype wire

/* File: test_mcu_instruction_execute.sv */
`timescale 1ns/1ps
`default_nettype none
module test_mcu_instruction_execute import mcuex_pkg::*;;
    typedef struct {
        mcuex_op_t  o;
        logic [2:0] b;
        logic [7:0] x, a, m, f, ea, em, ef;
        int         en;
    } mcuex_case_t;
    logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp;
    logic        busy, halted, wdt_clear, wdc;
    logic [1:0]  htrans;
    logic [2:0]  hsize;
    logic [31:0] haddr, hwdata, hrdata, rd, r_acc, r_mem, r_flg, r_pc;
    logic [12:0] pm_addr;
    logic [15:0] pm_word;
    int          mismatches, check_count, n;
    mcuex_case_t c;
    mcuex_case_t tbl[$] = '{
        '{OP_ADC_AM,3'h0,8'h40,8'h7F,8'h00,8'h01,8'h80,8'h00,8'h0A,4},
        '{OP_ADDM,3'h0,8'h40,8'h80,8'h80,8'h00,8'h80,8'h00,8'h0D,4},
        '{OP_ADD_AX,3'h0,8'h01,8'hFF,8'h00,8'h00,8'h00,8'h00,8'h07,4},
        '{OP_SUB_AM,3'h0,8'h40,8'h10,8'h01,8'h00,8'h0F,8'h01,8'h01,4},
        '{OP_DADJ,3'h0,8'h40,8'h9A,8'h00,8'h04,8'h9A,8'h00,8'h05,4},
        '{OP_XOR_AX,3'h0,8'hFF,8'hFF,8'h00,8'h09,8'h00,8'h00,8'h0D,4},
        '{OP_CPLA,3'h0,8'h40,8'h00,8'h0F,8'h04,8'hF0,8'h0F,8'h00,4},
        '{OP_DEC,3'h0,8'h40,8'h00,8'h01,8'h00,8'h00,8'h00,8'h04,4},
        '{OP_RL,3'h0,8'h40,8'h00,8'h81,8'h00,8'h00,8'h03,8'h00,4},
        '{OP_RLC,3'h0,8'h40,8'h00,8'h81,8'h00,8'h00,8'h02,8'h01,4},
        '{OP_MOV_AM,3'h0,8'h40,8'h00,8'h77,8'h04,8'h77,8'h77,8'h04,4},
        '{OP_MOV_MA,3'h0,8'h40,8'h5A,8'h00,8'h0F,8'h5A,8'h5A,8'h0F,4},
        '{OP_MOV_MA,3'h0,8'h02,8'h5A,8'h00,8'h00,8'h5A,8'h00,8'h00,8},
        '{OP_SETB,3'h7,8'h40,8'h00,8'h00,8'h00,8'h00,8'h80,8'h00,4},
        '{OP_CLRB,3'h0,8'h40,8'h00,8'hFF,8'h00,8'h00,8'hFE,8'h00,4},
        '{OP_SZ,3'h0,8'h40,8'h00,8'h00,8'h00,8'h00,8'h00,8'h00,8},
        '{OP_SZ,3'h0,8'h40,8'h00,8'h01,8'h00,8'h00,8'h01,8'h00,4},
        '{OP_SWAP,3'h0,8'h40,8'h00,8'h3C,8'h00,8'h00,8'hC3,8'h00,4},
        '{OP_CLRM,3'h0,8'h40,8'h00,8'hFF,8'h0F,8'h00,8'h00,8'h0F,4},
        '{OP_SETM,3'h0,8'h40,8'h00,8'h00,8'h00,8'h00,8'hFF,8'h00,4},
        '{OP_WDCLR,3'h0,8'h40,8'h00,8'h00,8'h30,8'h00,8'h00,8'h00,4},
        '{OP_HALT,3'h0,8'h40,8'h00,8'h00,8'h20,8'h00,8'h00,8'h10,0}};

    mcuex_exec mcuex_exec_i (
        .hclk      (hclk),
        .hresetn   (hresetn),
        .hsel      (hsel),
        .haddr     (haddr),
        .htrans    (htrans),
        .hwrite    (hwrite),
        .hsize     (hsize),
        .hwdata    (hwdata),
        .hready    (hreadyout),
        .hrdata    (hrdata),
        .hreadyout (hreadyout),
        .hresp     (hresp),
        .busy      (busy),
        .halted    (halted),
        .wdt_clear (wdt_clear)
    );
    mcuex_prog_mem mcuex_prog_mem_i (
        .addr (pm_addr),
        .word (pm_word)
    );

    // Free-running bus clock
    initial begin
        hclk = 1'b0;
        forever #12.5 hclk = ~hclk;
    end

    task automatic end_sim;
        $display("checks %0d mismatches %0d", check_count, mismatches);
        if (mismatches == 0 && check_count > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    task automatic check(input logic [31:0] s, input logic [31:0] e);
        check_count++;
        if (s !== e) begin
            mismatches++;
            $display("FAIL t=%0t seen=%h exp=%h", $time, s, e);
        end
    endtask

    // One single transfer; read data lands in rd
    task automatic ahb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        @(posedge hclk);
        hsel <= 1'b1;
        htrans <= 2'b10;
        hwrite <= w;
        haddr <= {24'h0, a};
        do @(posedge hclk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= d;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask

    function automatic logic [31:0] iw(input mcuex_op_t o,
        input logic [2:0] b, input logic [12:0] t);
        return {3'h0, t, 5'h00, b, 2'h0, o};
    endfunction

    // Load operands, launch, time busy, read results back
    task automatic run(input logic [31:0] ins, input logic [7:0] a, m, f);
        ahb(1'b1, 8'h04, {24'h0, a});
        ahb(1'b1, 8'h08, {24'h0, m});
        ahb(1'b1, 8'h0C, {24'h0, f});
        ahb(1'b1, 8'h00, ins);
        #1;
        wdc = wdt_clear;
        n = 0;
        while (busy === 1'b1 && n < 64) begin
            @(posedge hclk);
            #1;
            n++;
        end
        if (n == 64) mismatches++;
        ahb(1'b0, 8'h04, 32'h0);
        r_acc = rd;
        ahb(1'b0, 8'h08, 32'h0);
        r_mem = rd;
        ahb(1'b0, 8'h0C, 32'h0);
        r_flg = rd;
        ahb(1'b0, 8'h10, 32'h0);
        r_pc = rd;
    endtask

    // Unmapped read, then a launch refused while busy
    task automatic t_bus;
        ahb(1'b0, 8'h3C, 32'h0);
        check(rd, 32'h0);
        ahb(1'b1, 8'h00, iw(OP_MOV_AX, 3'h0, 13'h0011));
        ahb(1'b1, 8'h00, iw(OP_MOV_AX, 3'h0, 13'h0022));
        ahb(1'b0, 8'h04, 32'h0);
        check(rd, 32'h11);
    endtask

    task automatic t_cases;
        foreach (tbl[i]) begin
            c = tbl[i];
            run(iw(c.o, c.b, {5'h00, c.x}), c.a, c.m, c.f);
            check(r_acc, {24'h0, c.ea});
            if (c.x != 8'h02) check(r_mem, {24'h0, c.em});
            check(r_flg, {24'h0, c.ef});
            if (c.en != 0) check(32'(n), 32'(c.en));
            check({31'h0, wdc},
                  {31'h0, c.o inside {OP_WDCLR, OP_HALT}});
            check({31'h0, halted}, {31'h0, c.o == OP_HALT});
            if (halted === 1'b1) ahb(1'b1, 8'h1C, 32'h2);
        end
    endtask

    // Two-times option: only the second pre-clear clears
    task automatic t_preclear;
        ahb(1'b1, 8'h1C, 32'h1);
        run(iw(OP_WDP1, 3'h0, 13'h0040), 8'h00, 8'h00, 8'h30);
        check(r_flg, 32'h30);
        check({31'h0, wdc}, 32'h0);
        run(iw(OP_WDP2, 3'h0, 13'h0040), 8'h00, 8'h00, 8'h30);
        check(r_flg, 32'h0);
        check({31'h0, wdc}, 32'h1);
        ahb(1'b1, 8'h1C, 32'h0);
    endtask

    task automatic t_flow;
        run(iw(OP_JMP, 3'h0, 13'h0123), 8'h00, 8'h00, 8'h00);
        check(r_pc, 32'h123);
        run(iw(OP_CALL, 3'h0, 13'h0456), 8'h00, 8'h00, 8'h00);
        check(r_pc, 32'h456);
        check(32'(n), 32'h8);
        run(iw(OP_RETAX, 3'h0, 13'h0099), 8'h00, 8'h00, 8'h00);
        check(r_pc, 32'h124);
        check(r_acc, 32'h99);
    endtask

    // Word from the program memory model into memory and latch
    task automatic t_table;
        pm_addr = 13'h1F40;
        #1;
        ahb(1'b1, 8'h14, {16'h0, pm_word});
        run(iw(OP_TBRL, 3'h0, 13'h0040), 8'h00, 8'h40, 8'h00);
        check(r_mem, {24'h0, pm_word[7:0]});
        check(32'(n), 32'h8);
        ahb(1'b0, 8'h18, 32'h0);
        check({24'h0, rd[7:0]}, {24'h0, pm_word[15:8]});
        check({19'h0, rd[20:8]}, {19'h0, pm_addr});
    endtask

    initial begin
        hresetn = 1'b0;
        hsel = 1'b0;
        haddr = 32'h0;
        htrans = 2'b00;
        hwrite = 1'b0;
        hsize = 3'b010;
        hwdata = 32'h0;
        pm_addr = 13'h0000;
        repeat (10) @(posedge hclk);
        hresetn <= 1'b1;
        t_bus;
        t_cases;
        t_preclear;
        t_flow;
        t_table;
        end_sim;
    end

    // Hang guard, well beyond the expected run length
    initial begin
        #(25 * 8000);
        mismatches++;
        end_sim;
    end
endmodule
`default_nettype wire
